/* File: design/ciel_params.svh */
// Offsets, field positions, reset values and timing for the card interrupt event logic
`ifndef CIEL_PARAMS_SVH
`define CIEL_PARAMS_SVH
// ==========================================================
// Register spaces
`define CIEL_SP_LEGACY      2'h0
`define CIEL_SP_CONFIG      2'h1
`define CIEL_SP_CBSOCK      2'h2
// ==========================================================
// Offsets
`define CIEL_OFF_EVT_FLAGS  12'h004
`define CIEL_OFF_EVT_MASK   12'h005
`define CIEL_OFF_GLB_CTRL   12'h01E
`define CIEL_OFF_FUNC_STAT  12'h091
`define CIEL_OFF_DEV_CTRL   12'h092
`define CIEL_OFF_ROUTE      12'h093
`define CIEL_OFF_CB_EVENT   12'h000
`define CIEL_OFF_CB_MASK    12'h004
// ==========================================================
// Field positions
`define CIEL_GLB_CLR_MODE   2
`define CIEL_DEV_MODE_LO    1
`define CIEL_LEG_BATTERY_DETECT_ONE_STS   0
`define CIEL_LEG_BATTERY_DETECT_TWO       1
`define CIEL_LEG_READY      2
`define CIEL_EVT_PWR        3
`define CIEL_CB_IO_CARD_STATUS_CHANGE      0
`define CIEL_CB_CD1         1
`define CIEL_CB_CD2         2
`define CIEL_PIN_CD1        0
`define CIEL_PIN_CD2        1
`define CIEL_PIN_BATTERY_DETECT_ONE       2
`define CIEL_PIN_BATTERY_DETECT_TWO       3
`define CIEL_PIN_RDY        4
// ==========================================================
// Reset values
`define CIEL_RST_FLAGS      4'h0
`define CIEL_RST_MASK       4'h0
`define CIEL_RST_GLB        8'h00
`define CIEL_RST_MODE       2'h3
`define CIEL_RST_ROUTE      3'h0
`define CIEL_RST_TERM       7'h41
`define CIEL_RST_PINS       5'h03
// ==========================================================
// Timing
`define CIEL_CLK_NS         8
`define CIEL_PWR_UP_NS      100000
`endif

/* File: design/ciel_pkg.sv */
// Types for the card interrupt event logic
package ciel_pkg;
	typedef enum logic [1:0] {
		CIEL_CT_NONE = 2'b00,
		CIEL_CT_MEM  = 2'b01,
		CIEL_CT_IO   = 2'b10,
		CIEL_CT_CB   = 2'b11
	} ciel_card_t;
	typedef enum logic [1:0] {
		CIEL_SIG_PCI      = 2'b00,
		CIEL_SIG_PIRQ     = 2'b01,
		CIEL_SIG_SIRQ_PCI = 2'b10,
		CIEL_SIG_SIRQ_ALL = 2'b11
	} ciel_sig_t;
	typedef enum logic [1:0] {
		CIEL_PWR_IDLE = 2'b00,
		CIEL_PWR_RAMP = 2'b01,
		CIEL_PWR_DONE = 2'b10
	} ciel_pwr_t;
endpackage

/* File: design/ciel_card_interrupt_event_logic.sv */
// Card socket event detection, flags, masks and host interrupt terminals
`timescale 1ns/1ns
`include "ciel_params.svh"
module ciel_card_interrupt_event_logic
	import ciel_pkg::*;
#(
	parameter int PWR_UP_CYCLES = (`CIEL_PWR_UP_NS + `CIEL_CLK_NS - 1) / `CIEL_CLK_NS
) (
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	input  wire logic       card_detect_one_n_i,
	input  wire logic       card_detect_two_n_i,
	input  wire logic       battery_detect_one_i,
	input  wire logic       battery_detect_two_i,
	input  wire logic       ready_irq_request_i,
	input  wire ciel_card_t card_type_i,
	input  wire logic       power_request_i,
	input  wire logic [1:0] reg_space_i,
	input  wire logic [11:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	output logic      [6:0] shared_function_terminals_o
);
	localparam int CW = $clog2(PWR_UP_CYCLES + 1);

	function automatic logic hit(input logic [1:0] sp, input logic [11:0] off);
		hit = (reg_space_i == sp) && (reg_addr_i == off);
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [4:0] pin_raw;
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] s3_q;
	logic [4:0] st_q;
	logic [4:0] prev_q;
	logic [4:0] chg;
	logic [4:0] rise;
	logic [4:0] fall;

	assign pin_raw = {ready_irq_request_i, battery_detect_two_i, battery_detect_one_i,
		card_detect_two_n_i, card_detect_one_n_i};

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			s1_q <= `CIEL_RST_PINS;
			s2_q <= `CIEL_RST_PINS;
			s3_q <= `CIEL_RST_PINS;
		end else begin
			s1_q <= pin_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Change accepted once second and third stages agree
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			st_q   <= `CIEL_RST_PINS;
			prev_q <= `CIEL_RST_PINS;
		end else begin
			st_q   <= (st_q & ~(s2_q ~^ s3_q)) | (s3_q & (s2_q ~^ s3_q));
			prev_q <= st_q;
		end
	end

	assign chg  = st_q ^ prev_q;
	assign rise = st_q & ~prev_q;
	assign fall = prev_q & ~st_q;

	// ==========================================================
	// Card type decode
	logic is_mem;
	logic is_io;
	logic is_cb;
	logic present;

	// One terminal: ready, I/O request or CardBus request by type
	assign is_mem  = (card_type_i == CIEL_CT_MEM);
	assign is_io   = (card_type_i == CIEL_CT_IO);
	assign is_cb   = (card_type_i == CIEL_CT_CB);
	assign present = ~st_q[`CIEL_PIN_CD1] & ~st_q[`CIEL_PIN_CD2];

	// ==========================================================
	// Power-up sequence
	ciel_pwr_t       pwr_q;
	logic [CW-1:0]   pwr_cnt_q;
	logic            pwr_evt_q;

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			pwr_q     <= CIEL_PWR_IDLE;
			pwr_cnt_q <= '0;
			pwr_evt_q <= 1'b0;
		end else begin
			pwr_evt_q <= 1'b0;
			case (pwr_q)
				CIEL_PWR_IDLE: begin
					pwr_cnt_q <= '0;
					if (power_request_i && present) begin
						pwr_q <= CIEL_PWR_RAMP;
					end
				end
				CIEL_PWR_RAMP: begin
					if (!power_request_i || !present) begin
						pwr_q <= CIEL_PWR_IDLE;
					end else if (pwr_cnt_q == CW'(PWR_UP_CYCLES - 1)) begin
						pwr_q     <= CIEL_PWR_DONE;
						pwr_evt_q <= 1'b1;
					end else begin
						pwr_cnt_q <= pwr_cnt_q + CW'(1);
					end
				end
				CIEL_PWR_DONE: begin
					if (!power_request_i || !present) begin
						pwr_q <= CIEL_PWR_IDLE;
					end
				end
				default: begin
					pwr_q <= CIEL_PWR_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Event sources
	logic [3:0] leg_set;
	logic [3:0] cb_set;

	assign leg_set[`CIEL_LEG_BATTERY_DETECT_ONE_STS] = (is_mem & chg[`CIEL_PIN_BATTERY_DETECT_ONE])
		| (is_io & fall[`CIEL_PIN_BATTERY_DETECT_ONE]);
	assign leg_set[`CIEL_LEG_BATTERY_DETECT_TWO]     = is_mem & chg[`CIEL_PIN_BATTERY_DETECT_TWO];
	assign leg_set[`CIEL_LEG_READY]    = is_mem & chg[`CIEL_PIN_RDY];
	assign leg_set[`CIEL_EVT_PWR]      = pwr_evt_q & ~is_cb;
	assign cb_set[`CIEL_CB_IO_CARD_STATUS_CHANGE]     = is_cb & rise[`CIEL_PIN_BATTERY_DETECT_ONE];
	assign cb_set[`CIEL_CB_CD1]        = chg[`CIEL_PIN_CD1];
	assign cb_set[`CIEL_CB_CD2]        = chg[`CIEL_PIN_CD2];
	assign cb_set[`CIEL_EVT_PWR]       = pwr_evt_q & is_cb;

	// ==========================================================
	// Registers
	logic [3:0] leg_flags_q;
	logic [3:0] leg_mask_q;
	logic [3:0] cb_evt_q;
	logic [3:0] cb_mask_q;
	logic [7:0] glb_q;
	ciel_sig_t  mode_q;
	logic [2:0] route_q;
	logic       func_q;
	logic       w1c_mode;
	logic [3:0] leg_clr;
	logic [3:0] cb_clr;

	assign w1c_mode = glb_q[`CIEL_GLB_CLR_MODE];
	// Legacy flags clear by read or by write of one, per global control; CardBus events by write of one only
	assign leg_clr = (reg_rd_i && hit(`CIEL_SP_LEGACY, `CIEL_OFF_EVT_FLAGS) && !w1c_mode) ? 4'hF :
		((reg_wr_i && hit(`CIEL_SP_LEGACY, `CIEL_OFF_EVT_FLAGS) && w1c_mode) ? reg_wdata_i[3:0] : 4'h0);
	assign cb_clr = (reg_wr_i && hit(`CIEL_SP_CBSOCK, `CIEL_OFF_CB_EVENT)) ? reg_wdata_i[3:0] : 4'h0;

	// Flags: set wins over clear
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			leg_flags_q <= `CIEL_RST_FLAGS;
			cb_evt_q    <= `CIEL_RST_FLAGS;
		end else begin
			leg_flags_q <= (leg_flags_q & ~leg_clr) | leg_set;
			cb_evt_q    <= (cb_evt_q & ~cb_clr) | cb_set;
		end
	end

	// Functional request, unmaskable, only I/O or CardBus cards
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			func_q <= 1'b0;
		end else begin
			func_q <= (is_io | is_cb) & ~st_q[`CIEL_PIN_RDY];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			leg_mask_q <= `CIEL_RST_MASK;
			cb_mask_q  <= `CIEL_RST_MASK;
			glb_q      <= `CIEL_RST_GLB;
			mode_q     <= ciel_sig_t'(`CIEL_RST_MODE);
			route_q    <= `CIEL_RST_ROUTE;
		end else if (reg_wr_i) begin
			if (hit(`CIEL_SP_LEGACY, `CIEL_OFF_EVT_MASK)) begin
				leg_mask_q <= reg_wdata_i[3:0];
			end
			if (hit(`CIEL_SP_CBSOCK, `CIEL_OFF_CB_MASK)) begin
				cb_mask_q <= reg_wdata_i[3:0];
			end
			if (hit(`CIEL_SP_LEGACY, `CIEL_OFF_GLB_CTRL)) begin
				glb_q <= reg_wdata_i;
			end
			if (hit(`CIEL_SP_CONFIG, `CIEL_OFF_DEV_CTRL)) begin
				mode_q <= ciel_sig_t'(reg_wdata_i[`CIEL_DEV_MODE_LO +: 2]);
			end
			if (hit(`CIEL_SP_CONFIG, `CIEL_OFF_ROUTE)) begin
				route_q <= reg_wdata_i[2:0];
			end
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			reg_rdata_o <= 8'h00;
			if (hit(`CIEL_SP_LEGACY, `CIEL_OFF_EVT_FLAGS)) reg_rdata_o <= {4'h0, leg_flags_q};
			if (hit(`CIEL_SP_LEGACY, `CIEL_OFF_EVT_MASK)) reg_rdata_o <= {4'h0, leg_mask_q};
			if (hit(`CIEL_SP_LEGACY, `CIEL_OFF_GLB_CTRL)) reg_rdata_o <= glb_q;
			if (hit(`CIEL_SP_CONFIG, `CIEL_OFF_FUNC_STAT)) reg_rdata_o <= {7'h00, func_q};
			if (hit(`CIEL_SP_CONFIG, `CIEL_OFF_DEV_CTRL)) reg_rdata_o <= {5'h00, mode_q, 1'b0};
			if (hit(`CIEL_SP_CONFIG, `CIEL_OFF_ROUTE)) reg_rdata_o <= {5'h00, route_q};
			if (hit(`CIEL_SP_CBSOCK, `CIEL_OFF_CB_EVENT)) reg_rdata_o <= {4'h0, cb_evt_q};
			if (hit(`CIEL_SP_CBSOCK, `CIEL_OFF_CB_MASK)) reg_rdata_o <= {4'h0, cb_mask_q};
		end
	end

	// ==========================================================
	// Host terminals
	logic       csc_any;
	logic [6:0] term_d;

	assign csc_any = |(leg_flags_q & leg_mask_q) | |(cb_evt_q & cb_mask_q);

	always_comb begin
		term_d = `CIEL_RST_TERM;
		case (mode_q)
			CIEL_SIG_PCI: begin
				term_d[0] = ~(csc_any | func_q);
			end
			CIEL_SIG_PIRQ: begin
				term_d[6:1] = 6'h00;
				term_d[0] = ~csc_any;
				if (route_q != 3'h0 && route_q != 3'h7) begin
					term_d[route_q] = func_q;
				end
			end
			CIEL_SIG_SIRQ_PCI: begin
				term_d[0] = ~csc_any;
				term_d[6] = ~func_q;
			end
			CIEL_SIG_SIRQ_ALL: begin
				term_d[6] = ~(csc_any | func_q);
			end
			default: begin
				term_d = `CIEL_RST_TERM;
			end
		endcase
	end

	// Registered interrupt exit toward the host
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			shared_function_terminals_o <= `CIEL_RST_TERM;
		end else begin
			shared_function_terminals_o <= term_d;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb_clk @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	AST_FUNC_NOT_MEM: assert property (is_mem |=> !func_q)
		else $error("functional request seen with memory card");
	AST_FUNC_UNMASKED: assert property ((is_io && !st_q[`CIEL_PIN_RDY]) |=> func_q)
		else $error("functional request lost for I/O card");
	AST_CD_EVENT: assert property (chg[`CIEL_PIN_CD1] |=> cb_evt_q[`CIEL_CB_CD1])
		else $error("card detect change not flagged");
	AST_BVD_MEM: assert property ((is_mem && chg[`CIEL_PIN_BATTERY_DETECT_TWO]) |=> leg_flags_q[`CIEL_LEG_BATTERY_DETECT_TWO])
		else $error("battery change not flagged");
	AST_READY_MEM: assert property ((is_mem && chg[`CIEL_PIN_RDY]) |=> leg_flags_q[`CIEL_LEG_READY])
		else $error("ready change not flagged");
	AST_IO_IO_CARD_STATUS_CHANGE: assert property ((is_io && fall[`CIEL_PIN_BATTERY_DETECT_ONE]) |=> leg_flags_q[0])
		else $error("I/O status change not flagged");
	AST_CB_IO_CARD_STATUS_CHANGE: assert property ((is_cb && rise[`CIEL_PIN_BATTERY_DETECT_ONE]) |=> cb_evt_q[0])
		else $error("CardBus status change not flagged");
	AST_CB_W1C: assert property ((cb_clr[1] && !cb_set[1]) |=> !cb_evt_q[1])
		else $error("CardBus event not cleared by write of one");
	AST_RD_CLEAR: assert property ((leg_clr == 4'hF && leg_set == 4'h0) |=> leg_flags_q == 4'h0)
		else $error("legacy flags not cleared by read");
	AST_PCI_LEVEL: assert property ((mode_q == CIEL_SIG_PCI && $stable(mode_q)) |=>
		shared_function_terminals_o[0] == !$past(csc_any || func_q))
		else $error("PCI line does not follow pending state");
	AST_PWR_EVT: assert property ((pwr_q == CIEL_PWR_RAMP && power_request_i && present
		&& pwr_cnt_q == CW'(PWR_UP_CYCLES - 1)) |=> pwr_evt_q ##1 !pwr_evt_q)
		else $error("power cycle complete pulse wrong");

	COV_INSERT: cover property (chg[`CIEL_PIN_CD1] ##1 cb_evt_q[`CIEL_CB_CD1]);
	COV_PWR_DONE: cover property (pwr_evt_q);
	COV_IRQ_ROUTE: cover property (mode_q == CIEL_SIG_PIRQ && func_q ##1 |shared_function_terminals_o[6:1]);
endmodule

/* File: bench/ciel_card_model.sv */
// Behavioural card in the socket: detect, battery, ready and request pins
`timescale 1ns/1ns
module ciel_card_model
	import ciel_pkg::*;
(
	input  wire logic ref_clk_i,
	output logic       card_detect_one_n_o,
	output logic       card_detect_two_n_o,
	output logic       battery_detect_one_o,
	output logic       battery_detect_two_o,
	output logic       ready_irq_request_o,
	output ciel_card_t card_type_o
);
	// ==========================================
	// Empty socket: detects pulled high, rest pulled low
	initial begin
		card_detect_one_n_o = 1'b1;
		card_detect_two_n_o = 1'b1;
		battery_detect_one_o = 1'b0;
		battery_detect_two_o = 1'b0;
		ready_irq_request_o = 1'b0;
		card_type_o = CIEL_CT_NONE;
	end
	// ==========================================
	// Insertion with idle pin levels per card type
	task automatic plug(input ciel_card_t t);
		@(negedge ref_clk_i);
		card_type_o = t;
		card_detect_one_n_o = 1'b0;
		card_detect_two_n_o = 1'b0;
		battery_detect_one_o = (t != CIEL_CT_CB);
		battery_detect_two_o = 1'b0;
		ready_irq_request_o = 1'b1;
	endtask
	task automatic unplug();
		@(negedge ref_clk_i);
		card_type_o = CIEL_CT_NONE;
		card_detect_one_n_o = 1'b1;
		card_detect_two_n_o = 1'b1;
		battery_detect_one_o = 1'b0;
		battery_detect_two_o = 1'b0;
		ready_irq_request_o = 1'b0;
	endtask
	// ==========================================
	// Card side pin levels, request line included
	task automatic drive(input logic b1, input logic b2, input logic rdy);
		@(negedge ref_clk_i);
		battery_detect_one_o = b1;
		battery_detect_two_o = b2;
		ready_irq_request_o = rdy;
	endtask
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the card interrupt event logic
`timescale 1ns/1ns
`include "ciel_params.svh"
module testbench
	import ciel_pkg::*;
;
	localparam int         PWR = 20;
	localparam logic [1:0] LEG = `CIEL_SP_LEGACY;
	localparam logic [1:0] CFG = `CIEL_SP_CONFIG;
	localparam logic [1:0] CBS = `CIEL_SP_CBSOCK;
	logic        ref_clk_i;
	logic        reset_i;
	logic        cd1_n;
	logic        cd2_n;
	logic        bat1;
	logic        bat2;
	logic        rdy;
	ciel_card_t  ctype;
	logic        power_request_i;
	logic [1:0]  reg_space_i;
	logic [11:0] reg_addr_i;
	logic        reg_wr_i;
	logic        reg_rd_i;
	logic [7:0]  reg_wdata_i;
	logic [7:0]  reg_rdata_o;
	logic [6:0]  terms;
	logic [7:0]  rd_v;
	int          errors;
	int          num_checks;
	// ==========================================
	// Design, card and clock
	ciel_card_interrupt_event_logic #(.PWR_UP_CYCLES(PWR)) u_dut (
		.ref_clk_i(ref_clk_i), .reset_i(reset_i), .card_detect_one_n_i(cd1_n),
		.card_detect_two_n_i(cd2_n), .battery_detect_one_i(bat1), .battery_detect_two_i(bat2),
		.ready_irq_request_i(rdy), .card_type_i(ctype), .power_request_i(power_request_i),
		.reg_space_i(reg_space_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.shared_function_terminals_o(terms)
	);
	ciel_card_model u_card (
		.ref_clk_i(ref_clk_i), .card_detect_one_n_o(cd1_n), .card_detect_two_n_o(cd2_n),
		.battery_detect_one_o(bat1), .battery_detect_two_o(bat2),
		.ready_irq_request_o(rdy), .card_type_o(ctype)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #4 ref_clk_i = ~ref_clk_i;
	end
	// ==========================================
	// Shared tasks
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic waitn(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task automatic reg_wr(input logic [1:0] sp, input logic [11:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		reg_space_i = sp;
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] sp, input logic [11:0] a, output logic [7:0] d);
		@(negedge ref_clk_i);
		reg_space_i = sp;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		d = reg_rdata_o;
	endtask
	task automatic rd_chk(input logic [1:0] sp, input logic [11:0] a, input logic [7:0] e);
		logic [7:0] v;
		reg_rd(sp, a, v);
		check(v, e);
	endtask
	task automatic term_chk(input logic [6:0] m, input logic [6:0] e);
		waitn(2);
		check({1'b0, terms & m}, {1'b0, e});
	endtask
	task automatic swap(input ciel_card_t t);
		u_card.unplug();
		waitn(8);
		u_card.plug(t);
		waitn(8);
		reg_wr(CBS, `CIEL_OFF_CB_EVENT, 8'h0F);
		reg_rd(LEG, `CIEL_OFF_EVT_FLAGS, rd_v);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		check({1'b0, terms}, 8'h41);
		rd_chk(LEG, `CIEL_OFF_EVT_MASK, 8'h00);
		rd_chk(LEG, `CIEL_OFF_GLB_CTRL, 8'h00);
		rd_chk(CFG, `CIEL_OFF_DEV_CTRL, 8'h06);
		$display("test reset done");
	endtask
	task automatic t_insert();
		u_card.plug(CIEL_CT_MEM);
		waitn(8);
		rd_chk(CBS, `CIEL_OFF_CB_EVENT, 8'h06);
		term_chk(7'h7F, 7'h41);
		reg_wr(CBS, `CIEL_OFF_CB_MASK, 8'h06);
		term_chk(7'h7F, 7'h01);
		reg_wr(CBS, `CIEL_OFF_CB_EVENT, 8'h02);
		term_chk(7'h7F, 7'h01);
		rd_chk(CBS, `CIEL_OFF_CB_EVENT, 8'h04);
		reg_wr(CBS, `CIEL_OFF_CB_EVENT, 8'h04);
		term_chk(7'h7F, 7'h41);
		reg_wr(CBS, `CIEL_OFF_CB_MASK, 8'h00);
		$display("test insert done");
	endtask
	task automatic t_memory();
		reg_rd(LEG, `CIEL_OFF_EVT_FLAGS, rd_v);
		reg_wr(LEG, `CIEL_OFF_EVT_MASK, 8'h07);
		u_card.drive(1'b0, 1'b1, 1'b0);
		waitn(8);
		rd_chk(CFG, `CIEL_OFF_FUNC_STAT, 8'h00);
		term_chk(7'h7F, 7'h01);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h07);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h00);
		term_chk(7'h7F, 7'h41);
		reg_wr(LEG, `CIEL_OFF_GLB_CTRL, 8'h04);
		u_card.drive(1'b1, 1'b1, 1'b0);
		waitn(8);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h01);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h01);
		reg_wr(LEG, `CIEL_OFF_EVT_FLAGS, 8'h01);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h00);
		reg_wr(LEG, `CIEL_OFF_GLB_CTRL, 8'h00);
		reg_wr(LEG, `CIEL_OFF_EVT_MASK, 8'h00);
		power_request_i = 1'b1;
		waitn(PWR + 12);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h08);
		power_request_i = 1'b0;
		$display("test memory done");
	endtask
	task automatic t_io();
		logic [6:0] msk[4] = '{7'h01, 7'h7F, 7'h41, 7'h41};
		logic [6:0] exp[4] = '{7'h00, 7'h09, 7'h01, 7'h01};
		swap(CIEL_CT_IO);
		u_card.drive(1'b0, 1'b0, 1'b0);
		waitn(8);
		rd_chk(LEG, `CIEL_OFF_EVT_FLAGS, 8'h01);
		rd_chk(CFG, `CIEL_OFF_FUNC_STAT, 8'h01);
		reg_wr(CFG, `CIEL_OFF_FUNC_STAT, 8'h00);
		rd_chk(CFG, `CIEL_OFF_FUNC_STAT, 8'h01);
		rd_chk(LEG, 12'h0FF, 8'h00);
		reg_wr(CFG, `CIEL_OFF_ROUTE, 8'h03);
		for (int i = 0; i < 4; i++) begin
			reg_wr(CFG, `CIEL_OFF_DEV_CTRL, 8'(i << 1));
			term_chk(msk[i], exp[i]);
		end
		u_card.drive(1'b1, 1'b0, 1'b1);
		$display("test io done");
	endtask
	task automatic t_cardbus();
		swap(CIEL_CT_CB);
		u_card.drive(1'b1, 1'b0, 1'b0);
		waitn(8);
		rd_chk(CBS, `CIEL_OFF_CB_EVENT, 8'h01);
		rd_chk(CFG, `CIEL_OFF_FUNC_STAT, 8'h01);
		reg_wr(CBS, `CIEL_OFF_CB_EVENT, 8'h01);
		power_request_i = 1'b1;
		waitn(PWR / 2);
		power_request_i = 1'b0;
		waitn(PWR + 4);
		rd_chk(CBS, `CIEL_OFF_CB_EVENT, 8'h00);
		power_request_i = 1'b1;
		waitn(PWR + 12);
		rd_chk(CBS, `CIEL_OFF_CB_EVENT, 8'h08);
		power_request_i = 1'b0;
		$display("test cardbus done");
	endtask
	// ==========================================
	// Verdict, watchdog and main sequence
	task automatic final_report();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		errors++;
		final_report();
	end
	initial begin
		reset_i = 1'b1;
		power_request_i = 1'b0;
		reg_space_i = 2'h0;
		reg_addr_i = 12'h000;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_wdata_i = 8'h00;
		waitn(4);
		reset_i = 1'b0;
		waitn(1);
		t_reset();
		t_insert();
		t_memory();
		t_io();
		t_cardbus();
		final_report();
	end
endmodule
